/* File: verilog/serial_port_pkg.sv */
// shared constants and types for the full-duplex serial port
package serial_port_pkg;

  // special function register addresses
  localparam logic [7:0] CTRL_STATUS_ADDR = 8'h98;
  localparam logic [7:0] DATA_BUF_ADDR = 8'h99;

  // control/status bit positions
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_FILTER = 5;
  localparam int BIT_RX_EN = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // divider terminal counts: shift mode 12 clocks per bit, uart 16 ticks per bit
  localparam logic [3:0] SHIFT_LAST = 4'hB;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SCLK_LOW_FIRST = 4'h4;
  localparam logic [3:0] SCLK_LOW_LAST = 4'h9;
  localparam logic [3:0] SHIFT_SAMPLE = 4'h9;
  localparam logic [3:0] VOTE_A = 4'h6;
  localparam logic [3:0] VOTE_B = 4'h7;
  localparam logic [3:0] VOTE_C = 4'h8;

  // fixed-rate prescaler: 4 clocks x 16 = osc/64, 2 clocks x 16 = osc/32
  localparam logic [1:0] PRE_LAST_64 = 2'h3;
  localparam logic [1:0] PRE_LAST_32 = 2'h1;

  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_UART8 = 2'h1,
    MODE_UART9_FIXED = 2'h2,
    MODE_UART9_VAR = 2'h3
  } mode_t;

  // gray coded along idle -> start -> data -> ninth -> stop
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_NINTH = 3'h2,
    ST_STOP = 3'h6
  } frame_state_t;

endpackage

/* File: verilog/bit_timer.sv */
// bit-time divider: counts step pulses and flags the last one of each bit
`timescale 1ns/1ps
`default_nettype none
module bit_timer
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic step,
  input wire logic [3:0] last,
  output logic [3:0] count,
  output logic wrap
);

  logic [3:0] count_ff;
  logic [3:0] nxt_count;

  // wrap is combinational so the caller acts in the same cycle as the last step
  assign wrap = step && (count_ff == last);
  assign nxt_count = clear ? 4'h0 : wrap ? 4'h0 : step ? count_ff + 4'h1 : count_ff;
  assign count = count_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_ff <= 4'h0;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/full_duplex_serial_port.sv */
// full-duplex serial port with shared data buffer and control/status register
`timescale 1ns/1ps
`default_nettype none
module full_duplex_serial_port
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic baud_double,
  input wire logic tx_timer_tick,
  input wire logic rx_timer_tick,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n,
  output logic txd,
  output logic serial_irq
);

  // software-owned control bits and hardware flags
  logic [7:3] ctrl_ff;
  logic rx_ninth_bit_ff, tx_done_flag_ff, rx_done_flag_ff;
  logic [7:0] rx_buf_ff, tx_data_ff, rdata_ff;
  logic tx_pend_ff;
  logic [1:0] pre_ff;
  logic rxd_s1_ff, rxd_s2_ff, rxd_s3_ff, rxd_f_ff, rxd_prev_ff;
  frame_state_t tx_st_ff, rx_st_ff;
  logic [2:0] tx_cnt_ff, rx_cnt_ff, vote_ff;
  logic [7:0] tx_shift_ff, rx_shift_ff;
  logic tx_line_ff, rx_ninth_ff, shift_sample_ff;
  logic txd_ff, rxd_out_ff, rxd_oe_n_ff, irq_ff;

  // register decode
  wire wr_ctrl = sfr_wr && (sfr_addr == CTRL_STATUS_ADDR);
  wire wr_buf = sfr_wr && (sfr_addr == DATA_BUF_ADDR);
  wire rd_ctrl = sfr_rd && (sfr_addr == CTRL_STATUS_ADDR);
  wire rd_buf = sfr_rd && (sfr_addr == DATA_BUF_ADDR);
  wire [7:0] ctrl_view = {ctrl_ff, rx_ninth_bit_ff, tx_done_flag_ff, rx_done_flag_ff};

  mode_t mode;
  assign mode = mode_t'({ctrl_ff[BIT_MODE_HI], ctrl_ff[BIT_MODE_LO]});
  wire mode0 = (mode == MODE_SHIFT);
  wire mode1 = (mode == MODE_UART8);
  wire nine_bit = ctrl_ff[BIT_MODE_HI];
  wire multiproc_filter = ctrl_ff[BIT_FILTER];
  wire rx_enable = ctrl_ff[BIT_RX_EN];
  wire tx_ninth_bit = ctrl_ff[BIT_TX_NINTH];

  // fixed-rate prescaler for mode 2; baud_double picks osc/32 over osc/64
  wire [1:0] pre_last = baud_double ? PRE_LAST_32 : PRE_LAST_64;
  wire pre_tick = (pre_ff == pre_last);
  wire [1:0] nxt_pre = pre_tick ? 2'h0 : pre_ff + 2'h1;

  // per-direction step source: separate timer ticks allow separate rates
  wire tx_step = mode0 ? 1'b1 : (mode == MODE_UART9_FIXED) ? pre_tick : tx_timer_tick;
  wire rx_step = mode0 ? 1'b1 : (mode == MODE_UART9_FIXED) ? pre_tick : rx_timer_tick;
  wire [3:0] bit_last = mode0 ? SHIFT_LAST : OVS_LAST;

  // receive start: falling edge of the filtered line, or mode 0 arming
  wire rx_fall = rxd_prev_ff && !rxd_f_ff;
  wire rx_arm0 = mode0 && rx_enable && !rx_done_flag_ff && (tx_st_ff == ST_IDLE);
  wire rx_begin = (rx_st_ff == ST_IDLE) && (mode0 ? rx_arm0 : (rx_enable && rx_fall));

  logic [3:0] tx_count, rx_count;
  logic tx_wrap, rx_wrap;

  bit_timer u_tx_timer (
    .clk(clk),
    .rst_n(rst_n),
    .clear(1'b0),
    .step(tx_step),
    .last(bit_last),
    .count(tx_count),
    .wrap(tx_wrap)
  );

  // rx timer restarts on a start edge to align with incoming bit cells
  bit_timer u_rx_timer (
    .clk(clk),
    .rst_n(rst_n),
    .clear(rx_begin),
    .step(rx_step),
    .last(bit_last),
    .count(rx_count),
    .wrap(rx_wrap)
  );

  // majority of three samples rejects noise; mode 0 takes one sample
  wire vote_maj = (vote_ff[0] & vote_ff[1]) | (vote_ff[0] & vote_ff[2]) | (vote_ff[1] & vote_ff[2]);
  wire rx_bit = mode0 ? shift_sample_ff : vote_maj;

  // frame ends
  wire tx_last_data = (tx_st_ff == ST_DATA) && (tx_cnt_ff == LAST_DATA_BIT);
  wire rx_last_data = (rx_st_ff == ST_DATA) && (rx_cnt_ff == LAST_DATA_BIT);
  wire tx_end = tx_wrap && ((tx_st_ff == ST_STOP) || (tx_last_data && mode0));
  wire rx_end = rx_wrap && rx_enable && ((rx_st_ff == ST_STOP) || (rx_last_data && mode0));
  // filter: ninth bit in modes 2/3, stop bit in mode 1; a still-set flag drops the byte
  wire filter_pass = mode0 || !multiproc_filter || (mode1 ? rx_bit : rx_ninth_ff);
  wire rx_accept = rx_end && !rx_done_flag_ff && filter_pass;
  wire rx_load_ninth = mode1 ? rx_bit : rx_ninth_ff;
  wire [7:0] rx_final_byte = mode0 ? {rx_bit, rx_shift_ff[7:1]} : rx_shift_ff;

  // flag next values: a hardware set beats a software clear in the same cycle
  wire nxt_tx_done = tx_end | (wr_ctrl ? sfr_wdata[BIT_TX_DONE] : tx_done_flag_ff);
  wire nxt_rx_done = rx_accept | (wr_ctrl ? sfr_wdata[BIT_RX_DONE] : rx_done_flag_ff);
  wire nxt_rx_ninth = (rx_accept && !mode0) ? rx_load_ninth :
                      wr_ctrl ? sfr_wdata[BIT_RX_NINTH] : rx_ninth_bit_ff;
  wire [7:0] nxt_rdata = rd_buf ? rx_buf_ff : rd_ctrl ? ctrl_view : READ_UNMAPPED;

  // control/status and data registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET[7:3];
      rx_ninth_bit_ff <= CTRL_RESET[BIT_RX_NINTH];
      tx_done_flag_ff <= CTRL_RESET[BIT_TX_DONE];
      rx_done_flag_ff <= CTRL_RESET[BIT_RX_DONE];
      rdata_ff <= READ_UNMAPPED;
      tx_data_ff <= 8'h00;
      pre_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= sfr_wdata[7:3];
      end
      if (wr_buf) begin
        tx_data_ff <= sfr_wdata;
      end
      rx_ninth_bit_ff <= nxt_rx_ninth;
      tx_done_flag_ff <= nxt_tx_done;
      rx_done_flag_ff <= nxt_rx_done;
      rdata_ff <= nxt_rdata;
      pre_ff <= nxt_pre;
      irq_ff <= nxt_tx_done | nxt_rx_done;
    end
  end

  // receive holding register, separate from the shift register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_buf_ff <= 8'h00;
    end else if (rx_accept) begin
      rx_buf_ff <= rx_final_byte;
    end
  end

  // pin synchroniser: stage one feeds stage two only; filtered level needs s2 == s3
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
      rxd_s3_ff <= 1'b1;
      rxd_f_ff <= 1'b1;
      rxd_prev_ff <= 1'b1;
    end else begin
      rxd_s1_ff <= rxd_in;
      rxd_s2_ff <= rxd_s1_ff;
      rxd_s3_ff <= rxd_s2_ff;
      if (rxd_s2_ff == rxd_s3_ff) begin
        rxd_f_ff <= rxd_s3_ff;
      end
      rxd_prev_ff <= rxd_f_ff;
    end
  end

  // transmit sequencer; bit times follow the free-running divider, not the write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_st_ff <= ST_IDLE;
      tx_cnt_ff <= 3'h0;
      tx_shift_ff <= 8'h00;
      tx_line_ff <= 1'b1;
      tx_pend_ff <= 1'b0;
    end else begin
      if (wr_buf) begin
        tx_pend_ff <= 1'b1;
      end else if (tx_wrap && tx_st_ff == ST_IDLE) begin
        tx_pend_ff <= 1'b0;
      end
      if (tx_wrap) begin
        case (tx_st_ff)
          ST_IDLE: begin
            if (tx_pend_ff) begin
              tx_shift_ff <= tx_data_ff;
              tx_cnt_ff <= 3'h0;
              tx_st_ff <= mode0 ? ST_DATA : ST_START;
              tx_line_ff <= mode0 ? tx_data_ff[0] : 1'b0;
            end
          end
          ST_START: begin
            tx_st_ff <= ST_DATA;
            tx_line_ff <= tx_shift_ff[0];
          end
          ST_DATA: begin
            tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
            tx_cnt_ff <= tx_cnt_ff + 3'h1;
            if (tx_cnt_ff != LAST_DATA_BIT) begin
              tx_line_ff <= tx_shift_ff[1];
            end else if (mode0) begin
              tx_st_ff <= ST_IDLE;
              tx_line_ff <= 1'b1;
            end else if (nine_bit) begin
              tx_st_ff <= ST_NINTH;
              tx_line_ff <= tx_ninth_bit;
            end else begin
              tx_st_ff <= ST_STOP;
              tx_line_ff <= 1'b1;
            end
          end
          ST_NINTH: begin
            tx_st_ff <= ST_STOP;
            tx_line_ff <= 1'b1;
          end
          ST_STOP: begin
            tx_st_ff <= ST_IDLE;
          end
          default: begin
            tx_st_ff <= ST_IDLE;
            tx_line_ff <= 1'b1;
          end
        endcase
      end
    end
  end

  // receive sequencer runs beside the transmitter on its own divider
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_st_ff <= ST_IDLE;
      rx_cnt_ff <= 3'h0;
      rx_shift_ff <= 8'h00;
      rx_ninth_ff <= 1'b0;
      vote_ff <= 3'h0;
      shift_sample_ff <= 1'b0;
    end else begin
      if (rx_step && rx_count == VOTE_A) vote_ff[0] <= rxd_f_ff;
      if (rx_step && rx_count == VOTE_B) vote_ff[1] <= rxd_f_ff;
      if (rx_step && rx_count == VOTE_C) vote_ff[2] <= rxd_f_ff;
      if (rx_count == SHIFT_SAMPLE) shift_sample_ff <= rxd_f_ff;
      if (!rx_enable) begin
        rx_st_ff <= ST_IDLE;
      end else if (rx_begin) begin
        rx_st_ff <= mode0 ? ST_DATA : ST_START;
        rx_cnt_ff <= 3'h0;
      end else if (rx_wrap) begin
        case (rx_st_ff)
          ST_START: begin
            // a high majority is a false start: go back to hunting
            rx_st_ff <= rx_bit ? ST_IDLE : ST_DATA;
          end
          ST_DATA: begin
            rx_shift_ff <= {rx_bit, rx_shift_ff[7:1]};
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
            if (rx_cnt_ff == LAST_DATA_BIT) begin
              rx_st_ff <= mode0 ? ST_IDLE : nine_bit ? ST_NINTH : ST_STOP;
            end
          end
          ST_NINTH: begin
            rx_ninth_ff <= rx_bit;
            rx_st_ff <= ST_STOP;
          end
          ST_STOP: begin
            rx_st_ff <= ST_IDLE;
          end
          default: begin
            rx_st_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // pin drive: mode 0 puts data on the rx pin and the shift clock on the tx pin
  wire tx0_active = mode0 && (tx_st_ff != ST_IDLE);
  wire rx0_active = mode0 && (rx_st_ff != ST_IDLE);
  wire [3:0] sclk_count = tx0_active ? tx_count : rx_count;
  wire sclk_low = (tx0_active || rx0_active) &&
                  (sclk_count >= SCLK_LOW_FIRST) && (sclk_count <= SCLK_LOW_LAST);
  wire nxt_txd = mode0 ? !sclk_low : tx_line_ff;
  wire nxt_rxd_out = tx0_active ? tx_line_ff : 1'b1;

  // registered pins; one cycle of latency is traded for glitch-free outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txd_ff <= 1'b1;
      rxd_out_ff <= 1'b1;
      rxd_oe_n_ff <= 1'b1;
    end else begin
      txd_ff <= nxt_txd;
      rxd_out_ff <= nxt_rxd_out;
      rxd_oe_n_ff <= !tx0_active;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign txd = txd_ff;
  assign rxd_out = rxd_out_ff;
  assign rxd_oe_n = rxd_oe_n_ff;
  assign serial_irq = irq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  tx_done_set_a: assert property (tx_end |=> tx_done_flag_ff)
    else $error("tx done flag not set at end of frame");
  rx_done_set_a: assert property (rx_accept |=> rx_done_flag_ff
      && rx_buf_ff == $past(rx_final_byte))
    else $error("rx done flag or buffer not loaded");
  ninth_filter_a: assert property (rx_end && nine_bit && multiproc_filter && !rx_ninth_ff
      && !rx_done_flag_ff && !wr_ctrl |=> !rx_done_flag_ff)
    else $error("filtered frame set rx done");
  stop_filter_a: assert property (rx_end && mode1 && multiproc_filter && !rx_bit
      && !rx_done_flag_ff && !wr_ctrl |=> !rx_done_flag_ff)
    else $error("bad stop bit set rx done in mode 1");
  overrun_hold_a: assert property (rx_end && rx_done_flag_ff |=> $stable(rx_buf_ff))
    else $error("unread byte overwritten");
  buf_read_a: assert property (rd_buf |=> sfr_rdata == $past(rx_buf_ff))
    else $error("data buffer read did not return receive register");
  buf_write_a: assert property (wr_buf |=> tx_data_ff == $past(sfr_wdata) && tx_pend_ff)
    else $error("data buffer write did not load transmit register");
  ctrl_read_a: assert property (rd_ctrl |=> sfr_rdata == $past(ctrl_view))
    else $error("control register readback wrong");
  start_bit_a: assert property (tx_wrap && tx_st_ff == ST_IDLE && tx_pend_ff && !mode0
      |=> ##1 !txd)
    else $error("start bit not low");
  tx_ninth_a: assert property (tx_wrap && tx_last_data && nine_bit
      |=> ##1 txd == $past(tx_ninth_bit, 2))
    else $error("ninth bit not sent");
  irq_follow_a: assert property (tx_done_flag_ff || rx_done_flag_ff |-> serial_irq)
    else $error("interrupt request missing");

  duplex_c: cover property (tx_st_ff == ST_DATA && rx_st_ff == ST_DATA);
  mode0_rx_c: cover property (rx_accept && mode0);
  filtered_c: cover property (rx_end && !filter_pass);

endmodule
`default_nettype wire

/* File: sim/remote_serial_model.sv */
// remote serial device: uart framer and deframer plus a shift-register responder
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  int bit_clks = 64;
  logic nine = 1'b0;
  logic shift_mode = 1'b0;
  logic [7:0] shift_q = 8'hFF;
  logic uart_level = 1'b1;
  logic [9:0] sh;
  logic [7:0] got_byte = 8'h00;
  logic got_ninth = 1'b0;
  logic got_stop = 1'b0;

  // idle line rests at the pull-up level; shift mode presents the next bit
  assign line_out = shift_mode ? shift_q[0] : uart_level;

  // start low, data lsb first, optional ninth, then stop
  task automatic send(input logic [7:0] d, input logic ninth, input logic stop);
    logic [10:0] fr;
    fr = nine ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    @(posedge clk);
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      uart_level <= fr[i];
      repeat (bit_clks) @(posedge clk);
    end
    uart_level <= 1'b1;
  endtask

  // deframer samples each bit at its middle, counted from the start edge
  always begin
    @(negedge line_in);
    if (!shift_mode) begin
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < (nine ? 10 : 9); i++) begin
        repeat (bit_clks) @(posedge clk);
        sh[i] = line_in;
      end
      got_byte = sh[7:0];
      got_ninth = nine & sh[8];
      got_stop = nine ? sh[9] : sh[8];
    end
  end

  // advance only after the rising shift clock, well past the device sample point
  always @(posedge line_in) begin
    if (shift_mode) shift_q <= {1'b1, shift_q[7:1]};
  end
endmodule
`default_nettype wire

/* File: sim/full_duplex_serial_port_tb_top.sv */
// self-checking testbench for the full-duplex serial port
`timescale 1ns/1ps
`default_nettype none
module full_duplex_serial_port_tb_top;
  import serial_port_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic baud_double = 1'b0;
  logic tick = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic rxd_out, rxd_oe_n, txd, serial_irq, far_line, rx_pin;
  logic [7:0] v;
  logic [7:0] got;
  logic [7:0] ctl [3] = '{8'h98, 8'h90, 8'hD8};
  int n_fail = 0;
  int checked = 0;

  // clock and a x16 tick every 4 clocks, so one uart bit spans 64 clocks
  always #25 clk = ~clk;
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    tick <= (tick_cnt == 2'h3);
  end

  // rx pin level: device drives it only while its enable is low
  assign rx_pin = rxd_oe_n ? far_line : rxd_out;

  full_duplex_serial_port DUT (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .baud_double(baud_double),
    .tx_timer_tick(tick), .rx_timer_tick(tick), .rxd_in(rx_pin), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .txd(txd), .serial_irq(serial_irq));

  remote_serial_model u_far (.clk(clk), .line_in(txd), .line_out(far_line));

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] seen);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle strobes, launched and dropped just after rising edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  // read data is registered: it stands in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  // bounded poll of one control/status flag
  task automatic wait_flag(input int b);
    for (int k = 0; k < 3000; k++) begin
      rd(CTRL_STATUS_ADDR, v);
      if (v[b] === 1'b1) return;
    end
    check("flag wait", 9'h1, 9'h0);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs roughly 7000 clocks
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(CTRL_STATUS_ADDR, v);
    check("ctrl after reset", {1'b0, CTRL_RESET}, {1'b0, v});
    check("irq after reset", 9'h0, {8'h00, serial_irq});
    rd(8'h42, v);
    check("unmapped read", 9'h0, {1'b0, v});
    // mode 1: send and receive at once
    wr(CTRL_STATUS_ADDR, 8'h50);
    fork
      u_far.send(8'h3C, 1'b0, 1'b1);
      wr(DATA_BUF_ADDR, 8'h81);
    join
    wait_flag(BIT_RX_DONE);
    wait_flag(BIT_TX_DONE);
    check("irq with flags", 9'h1, {8'h00, serial_irq});
    check("sent byte", 9'h081, {1'b0, u_far.got_byte});
    check("sent stop", 9'h1, {8'h00, u_far.got_stop});
    check("stop into rx ninth", 9'h1, {8'h00, v[BIT_RX_NINTH]});
    rd(DATA_BUF_ADDR, v);
    check("read gives rx byte", 9'h03C, {1'b0, v});
    // second byte assembles while the first is still held
    fork
      u_far.send(8'h11, 1'b0, 1'b1);
      begin
        repeat (200) @(posedge clk);
        rd(DATA_BUF_ADDR, v);
        check("held byte", 9'h03C, {1'b0, v});
        wr(CTRL_STATUS_ADDR, 8'h50);
        @(negedge clk);
        check("irq after clear", 9'h0, {8'h00, serial_irq});
      end
    join
    wait_flag(BIT_RX_DONE);
    rd(DATA_BUF_ADDR, v);
    check("second byte", 9'h011, {1'b0, v});
    u_far.send(8'h22, 1'b0, 1'b1);
    repeat (64) @(posedge clk);
    rd(DATA_BUF_ADDR, v);
    check("overrun keeps held", 9'h011, {1'b0, v});
    // mode 1 with filter: bad stop is dropped, good stop passes
    wr(CTRL_STATUS_ADDR, 8'h70);
    u_far.send(8'h44, 1'b0, 1'b0);
    repeat (64) @(posedge clk);
    rd(CTRL_STATUS_ADDR, v);
    check("bad stop dropped", 9'h0, {8'h00, v[BIT_RX_DONE]});
    u_far.send(8'h55, 1'b0, 1'b1);
    wait_flag(BIT_RX_DONE);
    rd(DATA_BUF_ADDR, v);
    check("filtered pass", 9'h055, {1'b0, v});
    // nine-bit modes: fixed /64, fixed /32, variable
    u_far.nine = 1'b1;
    for (int k = 0; k < 3; k++) begin
      baud_double <= (k == 1);
      u_far.bit_clks = (k == 1) ? 32 : 64;
      wr(CTRL_STATUS_ADDR, ctl[k]);
      fork
        u_far.send(8'h5A ^ 8'(k), ~ctl[k][3], 1'b1);
        wr(DATA_BUF_ADDR, 8'hA0 + 8'(k));
      join
      wait_flag(BIT_RX_DONE);
      wait_flag(BIT_TX_DONE);
      check("rx ninth", {8'h00, ~ctl[k][3]}, {8'h00, v[BIT_RX_NINTH]});
      check("nine-bit tx", {1'b0, 8'hA0 + 8'(k)}, {1'b0, u_far.got_byte});
      check("tx ninth", {8'h00, ctl[k][3]}, {8'h00, u_far.got_ninth});
      rd(DATA_BUF_ADDR, v);
      check("nine-bit rx", {1'b0, 8'h5A ^ 8'(k)}, {1'b0, v});
    end
    // mode 3 address filter
    wr(CTRL_STATUS_ADDR, 8'hF0);
    u_far.send(8'h66, 1'b0, 1'b1);
    repeat (64) @(posedge clk);
    rd(CTRL_STATUS_ADDR, v);
    check("ninth zero dropped", 9'h0, {8'h00, v[BIT_RX_DONE]});
    u_far.send(8'h77, 1'b1, 1'b1);
    wait_flag(BIT_RX_DONE);
    rd(DATA_BUF_ADDR, v);
    check("address frame", 9'h077, {1'b0, v});
    // mode 0 transmit: data on rx pin, shift clock on tx pin
    u_far.shift_mode = 1'b1;
    wr(CTRL_STATUS_ADDR, 8'h00);
    wr(DATA_BUF_ADDR, 8'hC3);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      got[i] = rxd_out;
      check("rx pin driven", 9'h0, {8'h00, rxd_oe_n});
    end
    wait_flag(BIT_TX_DONE);
    check("shift out", 9'h0C3, {1'b0, got});
    // mode 0 receive starts on enable with rx done clear
    u_far.shift_q = 8'h96;
    wr(CTRL_STATUS_ADDR, 8'h10);
    wait_flag(BIT_RX_DONE);
    rd(DATA_BUF_ADDR, v);
    check("shift in", 9'h096, {1'b0, v});
    end_of_test();
  end
endmodule
`default_nettype wire
